// ==== design/tmx_exec.sv ====
// execution of table write, software trap and exclusive-or
// What this block does
// RULE1: table write copies addressed data word to program address from accumulator low half
// RULE2: each transfer reads data memory first, then writes program memory
// RULE3: repeated table write increments program address by one per cycle
// RULE4: indirect mode updates current aux register and pointer once per word
// RULE5: seven address modification options including bit-reversed index add and subtract
// RULE6: optional next aux register field 0..7 selects new current register
// RULE7: single internal table write into dual-access RAM with internal code takes 3 cycles
// RULE8: repeated internal table write into dual-access RAM takes n+2 cycles
// RULE9: single write to external program takes 4+p, one more with external code
// RULE10: repeated external-to-external transfer takes 4n plus n times wait states
// RULE11: repeated transfer within one single-access RAM block takes 2n cycles
// RULE12: destination sharing block with code: single 4, repeated n+3 cycles
// RULE13: trap ignores and preserves the global interrupt mask
// RULE14: direct or indirect xor acts on accumulator 15:0, upper half kept
// RULE15: immediate xor shifts constant, zero fills, xors full accumulator
// RULE16: immediate xor shift 0..15 taken from first instruction word
// RULE17: xor never changes carry
// RULE18: table write saves program counter on micro stack, uses it, restores it
// RULE19: trap pushes next address on hardware stack and branches to 22h
// RULE20: fixed shift 16 immediate xor changes accumulator 31:16 only
`timescale 1ns/1ps
`default_nettype none
module tmx_exec (
  input wire logic clk_in, // 20 MHz clock
  input wire logic resetn_in, // asynchronous reset, active low
  input wire logic instr_valid_in, // instruction word offered
  input wire logic [15:0] instr_in, // instruction word
  input wire logic [15:0] pc_in, // address of the instruction
  input wire logic [15:0] lk_in, // second word, long immediate constant
  input wire logic [15:0] rpt_count_in, // repeat_next_instruction count, 0 for single
  input wire logic [6:0] data_page_pointer_in, // page for direct addressing
  input wire logic [15:0] dm_rdata_in, // data read from data memory
  input wire logic global_interrupt_mask_bit_in, // global interrupt mask
  input wire logic carry_in, // carry flag
  input wire tmx_pkg::tmx_place_t place_in, // operand placement and waits
  output logic busy_out, // instruction executing
  output logic done_out, // one-cycle completion pulse
  output logic [31:0] accumulator_register_out, // accumulator
  output logic [15:0] pc_out, // program counter
  output logic [15:0] hw_stack_push_out, // value pushed on hardware stack
  output logic hw_stack_push_valid_out, // push strobe
  output logic global_interrupt_mask_bit_out, // mask after instruction
  output logic carry_out, // carry after instruction
  output logic [2:0] aux_register_pointer_out, // current aux register pointer
  output logic [15:0] auxiliary_register_out, // current aux register value
  output tmx_pkg::tmx_mem_req_t mem_out, // memory request
  output logic [7:0] cycles_out // table-write cycle figure from placement and repeat count, computed when the last instruction was taken
);
  import tmx_pkg::*;
  tmx_state_t state_reg;
  logic [31:0] acc_reg;
  logic [15:0] ar_reg [0:7];
  logic [2:0] arp_reg;
  logic [15:0] pc_reg, micro_return_stack_reg;
  logic [15:0] rpt_reg;
  logic [15:0] instr_reg;
  logic [7:0] cyc_reg, cyc_target_reg;
  logic busy_reg, done_reg, push_valid_reg;
  logic [15:0] push_reg;
  tmx_mem_req_t mem_reg;
  logic [15:0] ar_next;
  logic [15:0] dm_addr_next;
  logic is_ind;
  logic ar_step;
  logic tw_last;
  logic mask_reg, carry_reg;
  logic [15:0] ar_out_reg;

  function automatic logic [7:0] tw_cycles(input tmx_place_t p, input logic [15:0] n);
    logic [7:0] nn, t;
    nn = n[7:0] + 8'h01;
    t = 8'h00;
    if (n == 16'h0000) begin
      if (p.dst == TMX_MEM_EXT)
        t = 8'(TW_BASE_EXT_DST) + 8'(p.wait_dst) + (p.code_ext ? 8'(TW_EXT_CODE) : 8'h00); // RULE9
      else
        t = 8'(TW_BASE_INT) + ((p.dst == TMX_MEM_SINGLE_ACCESS_RAM && p.dst_code_same) ? 8'(TW_SINGLE_ACCESS_RAM_CONFLICT) : 8'h00); // RULE7
      if (p.src == TMX_MEM_EXT)
        t = t + 8'(p.wait_src);
    end else if (p.src == TMX_MEM_EXT && p.dst == TMX_MEM_EXT) begin
      t = 8'(8'(TW_RPT_EXT_EXT) * nn + nn * 8'(p.wait_src) + nn * 8'(p.wait_dst)); // RULE10
    end else if (p.dst == TMX_MEM_SINGLE_ACCESS_RAM && p.src == TMX_MEM_SINGLE_ACCESS_RAM && p.src_dst_same) begin
      t = 8'(nn + nn); // RULE11
    end else if (p.dst == TMX_MEM_SINGLE_ACCESS_RAM && p.dst_code_same) begin
      t = nn + 8'(TW_BASE_INT); // RULE12
    end else if (p.dst == TMX_MEM_EXT) begin
      // each word waits for its own external write
      t = 8'(nn + nn + 8'(TW_RPT_SAME_SINGLE_ACCESS_RAM) + nn * 8'(p.wait_dst));
    end else begin
      t = nn + 8'(TW_RPT_SAME_SINGLE_ACCESS_RAM); // RULE8
      if (p.src == TMX_MEM_EXT)
        t = t + 8'(nn * 8'(p.wait_src));
    end
    if (p.code_ext && n != 16'h0000)
      t = t + 8'(p.wait_code);
    return t;
  endfunction

  // opcode decodes shared by sequencer, program counter and accumulator
  function automatic logic is_data_to_program_table_write(input logic [15:0] op);
    return op[15:8] == OP_DATA_TO_PROGRAM_TABLE_WRITE;
  endfunction

  function automatic logic is_xor_lk(input logic [15:0] op);
    return op[15:8] == OP_XOR_LK_HI && op[7:4] == {1'b0, OP_XOR_LK_LO};
  endfunction

  function automatic logic is_xor_mem(input logic [15:0] op);
    return op[15:8] == OP_XOR;
  endfunction

  assign is_ind = instr_reg[IND_BIT];
  // in indirect mode the aux unit steps on each table-write read and on a memory xor
  assign ar_step = is_ind && ((state_reg == TMX_ST_TW_READ) ||
                   (state_reg == TMX_ST_FETCH_LK && is_xor_mem(instr_reg)));
  assign tw_last = (state_reg == TMX_ST_TW_WAIT) && (cyc_reg + 8'h01 >= cyc_target_reg);
  assign dm_addr_next = is_ind ? ar_reg[arp_reg] : {2'b00, data_page_pointer_in, instr_reg[6:0]};

  tmx_aru #(.W(DW)) u_aru (
    .ar_in(ar_reg[arp_reg]),
    .index_in(ar_reg[0]),
    .aru_in(instr_reg[ARU_HI:ARU_LO]),
    .ar_out(ar_next)
  );

  // sequencer
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= TMX_ST_IDLE;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      instr_reg <= 16'h0000;
      rpt_reg <= 16'h0000;
      cyc_reg <= 8'h00;
      cyc_target_reg <= 8'h00;
    end else begin
      done_reg <= 1'b0;
      cyc_reg <= cyc_reg + 8'h01;
      case (state_reg)
        TMX_ST_IDLE: begin
          if (instr_valid_in) begin
            instr_reg <= instr_in;
            rpt_reg <= rpt_count_in;
            cyc_reg <= 8'h01;
            busy_reg <= 1'b1;
            cyc_target_reg <= tw_cycles(place_in, rpt_count_in);
            if (is_data_to_program_table_write(instr_in))
              state_reg <= TMX_ST_TW_READ;
            else
              state_reg <= TMX_ST_FETCH_LK;
          end
        end
        TMX_ST_FETCH_LK: begin
          state_reg <= TMX_ST_DONE;
        end
        TMX_ST_TW_READ: begin
          // one read per cycle; the write of each word trails it by one cycle
          if (rpt_reg != 16'h0000) begin
            rpt_reg <= rpt_reg - 16'h0001; // RULE3
          end else begin
            state_reg <= TMX_ST_TW_WRITE; // RULE2
          end
        end
        TMX_ST_TW_WRITE: begin
          // last read of the block is on the bus here; its write goes out in TMX_ST_TW_WAIT
          state_reg <= TMX_ST_TW_WAIT;
        end
        TMX_ST_TW_WAIT: begin
          // hold until the cycle count for this placement is used
          if (tw_last) begin
            state_reg <= TMX_ST_DONE; // RULE7 RULE8 RULE9 RULE10 RULE11 RULE12
          end
        end
        TMX_ST_DONE: begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          state_reg <= TMX_ST_IDLE;
        end
        default: state_reg <= TMX_ST_IDLE;
      endcase
    end
  end

  // memory strobes of the table write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_reg <= '0;
    end else begin
      mem_reg.dm_rd <= 1'b0;
      mem_reg.pm_wr <= 1'b0;
      // address comes from the current aux register or the page
      if (state_reg == TMX_ST_TW_READ) begin
        mem_reg.dm_rd <= 1'b1; // RULE2
        mem_reg.dm_addr <= dm_addr_next; // RULE1
      end
      // read data stands while the read strobe is high
      if (mem_reg.dm_rd) begin
        mem_reg.pm_wr <= 1'b1; // RULE2
        mem_reg.pm_addr <= pc_reg; // RULE1 RULE18
        mem_reg.pm_wdata <= dm_rdata_in; // RULE1
      end
    end
  end

  // program counter and micro stack
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_reg <= 16'h0000;
      micro_return_stack_reg <= 16'h0000;
      push_reg <= 16'h0000;
      push_valid_reg <= 1'b0;
    end else begin
      push_valid_reg <= 1'b0;
      if (state_reg == TMX_ST_IDLE && instr_valid_in) begin
        if (is_data_to_program_table_write(instr_in)) begin
          micro_return_stack_reg <= pc_in + 16'h0001; // RULE18
          pc_reg <= acc_reg[15:0]; // RULE1 RULE18
        end else if (instr_in == OP_TRAP) begin
          push_reg <= pc_in + 16'h0001; // RULE19
          push_valid_reg <= 1'b1; // RULE19
          pc_reg <= TRAP_VECTOR; // RULE19
        end else if (is_xor_lk(instr_in) || instr_in == OP_XOR_LK16) begin
          pc_reg <= pc_in + 16'h0002;
        end else begin
          pc_reg <= pc_in + 16'h0001;
        end
      end else if (mem_reg.dm_rd) begin
        pc_reg <= pc_reg + 16'h0001; // RULE3
      end else if (tw_last) begin
        pc_reg <= micro_return_stack_reg; // RULE18
      end
    end
  end

  // auxiliary registers, updated in indirect mode once per transferred word and once per memory xor
  for (genvar g = 0; g < 8; g++) begin : g_ar
    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        ar_reg[g] <= 16'h0000;
      end else if (ar_step && arp_reg == 3'(g)) begin
        ar_reg[g] <= ar_next; // RULE4 RULE5
      end
    end
  end

  // pointer moves only when the instruction names a next register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arp_reg <= 3'h0;
    end else if (ar_step && instr_reg[NBIT]) begin
      arp_reg <= instr_reg[NAR_HI:0]; // RULE4 RULE6
    end
  end

  // accumulator
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_reg <= 32'h00000000;
    end else if (state_reg == TMX_ST_FETCH_LK) begin
      if (instr_reg == OP_XOR_LK16)
        acc_reg[31:16] <= acc_reg[31:16] ^ lk_in; // RULE20
      else if (is_xor_lk(instr_reg))
        acc_reg <= acc_reg ^ ({16'h0000, lk_in} << instr_reg[SHIFT_HI:0]); // RULE15 RULE16
      else if (is_xor_mem(instr_reg))
        acc_reg[15:0] <= acc_reg[15:0] ^ dm_rdata_in; // RULE14
    end
  end

  // trap and xor leave mask and carry as they were; outputs are registered copies
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_reg <= 1'b0;
      carry_reg <= 1'b0;
    end else begin
      mask_reg <= global_interrupt_mask_bit_in; // RULE13
      carry_reg <= carry_in; // RULE17
    end
  end

  // current aux register value, one cycle behind a pointer or register change
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ar_out_reg <= 16'h0000;
    end else begin
      ar_out_reg <= ar_reg[arp_reg];
    end
  end

  assign busy_out = busy_reg;
  assign done_out = done_reg;
  assign accumulator_register_out = acc_reg;
  assign pc_out = pc_reg;
  assign hw_stack_push_out = push_reg;
  assign hw_stack_push_valid_out = push_valid_reg;
  assign global_interrupt_mask_bit_out = mask_reg;
  assign carry_out = carry_reg;
  assign aux_register_pointer_out = arp_reg;
  assign auxiliary_register_out = ar_out_reg;
  assign mem_out = mem_reg;
  assign cycles_out = cyc_target_reg;
endmodule
`default_nettype wire

// ==== design/tmx_pkg.sv ====
// package of constants and types for the table move, trap and xor execution block
package tmx_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 32;
  // opcode fields
  localparam logic [7:0] OP_DATA_TO_PROGRAM_TABLE_WRITE = 8'hA7;
  localparam logic [7:0] OP_XOR = 8'h6C;
  localparam logic [15:0] OP_TRAP = 16'hBE51;
  localparam logic [7:0] OP_XOR_LK_HI = 8'hBF;
  localparam logic [2:0] OP_XOR_LK_LO = 3'h5;
  localparam logic [15:0] OP_XOR_LK16 = 16'hBE83;
  localparam logic [15:0] TRAP_VECTOR = 16'h0022;
  localparam int unsigned IND_BIT = 7;
  localparam int unsigned ARU_HI = 6;
  localparam int unsigned ARU_LO = 4;
  localparam int unsigned NBIT = 3;
  localparam int unsigned NAR_HI = 2;
  localparam int unsigned SHIFT_HI = 3;
  localparam int unsigned XOR_HI_SHIFT = 16;
  localparam int unsigned DP_SHIFT = 7;
  // fixed cycle figures for table write timing
  localparam logic [3:0] TW_BASE_INT = 4'h3;
  localparam logic [3:0] TW_BASE_EXT_DST = 4'h4;
  localparam logic [3:0] TW_SINGLE_ACCESS_RAM_CONFLICT = 4'h1;
  localparam logic [3:0] TW_EXT_CODE = 4'h1;
  localparam logic [3:0] TW_RPT_EXT_EXT = 4'h4;
  localparam logic [3:0] TW_RPT_SAME_SINGLE_ACCESS_RAM = 4'h2;
  // memory class of an operand
  typedef enum logic [1:0] {
    TMX_MEM_DUAL_ACCESS_RAM = 2'b00,
    TMX_MEM_SINGLE_ACCESS_RAM = 2'b01,
    TMX_MEM_EXT = 2'b10,
    TMX_MEM_ROM = 2'b11
  } tmx_mem_t;
  // address-modification options
  typedef enum logic [2:0] {
    TMX_ARU_NONE = 3'b000,
    TMX_ARU_DEC = 3'b001,
    TMX_ARU_INC = 3'b010,
    TMX_ARU_RSVD = 3'b011,
    TMX_ARU_BR_SUB = 3'b100,
    TMX_ARU_SUB0 = 3'b101,
    TMX_ARU_ADD0 = 3'b110,
    TMX_ARU_BR_ADD = 3'b111
  } tmx_aru_t;
  typedef enum logic [2:0] {
    TMX_ST_IDLE = 3'b000,
    TMX_ST_FETCH_LK = 3'b001,
    TMX_ST_TW_READ = 3'b010,
    TMX_ST_TW_WRITE = 3'b011,
    TMX_ST_TW_WAIT = 3'b100,
    TMX_ST_DONE = 3'b101
  } tmx_state_t;
  // memory request from the block
  typedef struct packed {
    logic dm_rd;
    logic [15:0] dm_addr;
    logic pm_wr;
    logic [15:0] pm_addr;
    logic [15:0] pm_wdata;
  } tmx_mem_req_t;
  // placement of table-write operands and wait states
  typedef struct packed {
    tmx_mem_t src;
    tmx_mem_t dst;
    logic code_ext;
    logic dst_code_same;
    logic src_dst_same;
    logic [3:0] wait_src;
    logic [3:0] wait_dst;
    logic [3:0] wait_code;
  } tmx_place_t;
endpackage

// ==== design/tmx_aru.sv ====
// auxiliary register address update unit
`timescale 1ns/1ps
`default_nettype none
module tmx_aru #(
  parameter int unsigned W = 16
) (
  input wire logic [W-1:0] ar_in, // current auxiliary register
  input wire logic [W-1:0] index_in, // index register value
  input wire logic [2:0] aru_in, // modification option
  output logic [W-1:0] ar_out // updated value
);
  import tmx_pkg::*;
  function automatic logic [W-1:0] rev(input logic [W-1:0] v);
    logic [W-1:0] r;
    r = '0;
    for (int i = 0; i < W; i++) begin
      r[i] = v[W-1-i];
    end
    return r;
  endfunction
  always_comb begin
    case (tmx_aru_t'(aru_in))
      TMX_ARU_INC: ar_out = ar_in + W'(1); // RULE5
      TMX_ARU_DEC: ar_out = ar_in - W'(1); // RULE5
      TMX_ARU_ADD0: ar_out = ar_in + index_in; // RULE5
      TMX_ARU_SUB0: ar_out = ar_in - index_in; // RULE5
      // reverse-carry done by reversing, adding, reversing back
      TMX_ARU_BR_ADD: ar_out = rev(rev(ar_in) + rev(index_in)); // RULE5
      TMX_ARU_BR_SUB: ar_out = rev(rev(ar_in) - rev(index_in)); // RULE5
      default: ar_out = ar_in; // RULE5
    endcase
  end
endmodule
`default_nettype wire

// ==== sim/tmx_exec_monitor.sv ====
// assertion checker for the table move, trap and xor block
`timescale 1ns/1ps
`default_nettype none
module tmx_exec_chk
  import tmx_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic resetn_in, // reset, active low
  input wire logic instr_valid_in, // request
  input wire logic [15:0] instr_in, // instruction
  input wire logic [15:0] pc_in, // instruction address
  input wire logic [15:0] rpt_count_in, // repeat count
  input wire tmx_pkg::tmx_place_t place_in, // placement
  input wire logic carry_in, // carry in
  input wire logic global_interrupt_mask_bit_in, // mask in
  input wire logic busy_out, // busy
  input wire logic done_out, // done pulse
  input wire logic [31:0] accumulator_register_out, // accumulator
  input wire logic [15:0] pc_out, // program counter
  input wire logic [15:0] hw_stack_push_out, // pushed value
  input wire logic hw_stack_push_valid_out, // push strobe
  input wire logic global_interrupt_mask_bit_out, // mask out
  input wire logic carry_out, // carry out
  input wire tmx_pkg::tmx_mem_req_t mem_out, // memory request
  input wire logic [7:0] cycles_out // cycle count
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic take;
  assign take = instr_valid_in && !busy_out;
  chk_read_then_write: assert property (mem_out.dm_rd |=> mem_out.pm_wr)
    else $error("data read not followed by program write");
  chk_write_after_read: assert property (mem_out.pm_wr |-> $past(mem_out.dm_rd))
    else $error("program write without preceding data read");
  chk_mask_kept: assert property (global_interrupt_mask_bit_out == $past(global_interrupt_mask_bit_in))
    else $error("interrupt mask changed");
  chk_carry_kept: assert property (carry_out == $past(carry_in))
    else $error("carry changed");
  chk_trap_vector: assert property (take && instr_in == OP_TRAP |=> pc_out == TRAP_VECTOR
    && hw_stack_push_valid_out && hw_stack_push_out == $past(pc_in) + 16'h0001)
    else $error("trap branch or push wrong");
  chk_xor_keep_hi: assert property (take && instr_in[15:8] == OP_XOR |-> ##3 done_out
    && accumulator_register_out[31:16] == $past(accumulator_register_out[31:16], 3))
    else $error("xor changed upper accumulator");
  chk_xor16_keep_lo: assert property (take && instr_in == OP_XOR_LK16 |-> ##3 done_out
    && accumulator_register_out[15:0] == $past(accumulator_register_out[15:0], 3))
    else $error("high xor changed lower accumulator");
  chk_tw_single_int: assert property (take && instr_in[15:8] == OP_DATA_TO_PROGRAM_TABLE_WRITE && rpt_count_in == 16'h0000
    && place_in == '0 |-> ##[1:12] done_out ##1 cycles_out == 8'h03)
    else $error("single internal table write not three cycles");
  chk_pm_step: assert property (mem_out.pm_wr && $past(mem_out.pm_wr) |->
    mem_out.pm_addr == $past(mem_out.pm_addr) + 16'h0001)
    else $error("program address did not step by one");
  chk_done_once: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  cover property (take && instr_in == OP_TRAP);
  cover property (mem_out.pm_wr && $past(mem_out.pm_wr));
  cover property (done_out && cycles_out > 8'h05);
endmodule
bind tmx_exec tmx_exec_chk tmx_exec_chk_i (.clk_in(clk_in), .resetn_in(resetn_in),
  .instr_valid_in(instr_valid_in), .instr_in(instr_in), .pc_in(pc_in), .rpt_count_in(rpt_count_in),
  .place_in(place_in), .carry_in(carry_in), .global_interrupt_mask_bit_in(global_interrupt_mask_bit_in),
  .busy_out(busy_out), .done_out(done_out), .accumulator_register_out(accumulator_register_out),
  .pc_out(pc_out), .hw_stack_push_out(hw_stack_push_out), .hw_stack_push_valid_out(hw_stack_push_valid_out),
  .global_interrupt_mask_bit_out(global_interrupt_mask_bit_out), .carry_out(carry_out),
  .mem_out(mem_out), .cycles_out(cycles_out));
`default_nettype wire

// ==== sim/tmx_mem_model.sv ====
// data and program memory model answering table transfers
`timescale 1ns/1ps
`default_nettype none
module tmx_mem_model
  import tmx_pkg::*;
(
  input wire logic clk_in, // clock
  input wire tmx_pkg::tmx_mem_req_t mem_in, // request from the block
  input wire logic fixed_in, // serve the fixed word
  input wire logic [15:0] fixed_word_in, // word for xor operands
  output logic [15:0] rdata_out // read data
);
  logic [15:0] a_q = 16'h0000;
  logic [15:0] rda[$];
  logic [15:0] pma[$];
  logic [15:0] pmd[$];
  always @(posedge clk_in) begin
    if (mem_in.dm_rd) begin
      a_q <= mem_in.dm_addr;
      rda.push_back(mem_in.dm_addr);
    end
    if (mem_in.pm_wr) begin
      pma.push_back(mem_in.pm_addr);
      pmd.push_back(mem_in.pm_wdata);
    end
  end
  // read data stands while the strobe is high; between reads the lines show the inverse of the last word
  assign rdata_out = fixed_in ? fixed_word_in : (mem_in.dm_rd ? mem_in.dm_addr ^ 16'h5A3C : ~(a_q ^ 16'h5A3C));
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the table move, trap and xor block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  import tmx_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, vld = 1'b0, gim = 1'b0, cy = 1'b0, fix = 1'b0;
  logic [15:0] ins = 16'h0000, pc = 16'h0000, lk = 16'h0000, repeat_next_instruction = 16'h0000, xw = 16'h0000, dmr;
  logic [6:0] dp = 7'h00;
  tmx_place_t pl = '0;
  tmx_mem_req_t mem;
  logic busy, done, push_v, gim_o, cy_o;
  logic [31:0] acc, acc_e = 32'h0;
  logic [15:0] pc_o, push, ar;
  logic [2:0] aux_register_pointer;
  logic [7:0] cyc;
  int num_errors = 0, n_compared = 0, tick = 0, b, s;
  tmx_exec tmx_exec_i (.clk_in(clk_in), .resetn_in(resetn_in), .instr_valid_in(vld), .instr_in(ins),
    .pc_in(pc), .lk_in(lk), .rpt_count_in(repeat_next_instruction), .data_page_pointer_in(dp), .dm_rdata_in(dmr),
    .global_interrupt_mask_bit_in(gim), .carry_in(cy), .place_in(pl), .busy_out(busy), .done_out(done),
    .accumulator_register_out(acc), .pc_out(pc_o), .hw_stack_push_out(push), .hw_stack_push_valid_out(push_v),
    .global_interrupt_mask_bit_out(gim_o), .carry_out(cy_o), .aux_register_pointer_out(aux_register_pointer),
    .auxiliary_register_out(ar), .mem_out(mem), .cycles_out(cyc));
  tmx_mem_model tmx_mem_model_i (.clk_in(clk_in), .mem_in(mem), .fixed_in(fix), .fixed_word_in(xw),
    .rdata_out(dmr));
  initial forever #25 clk_in = ~clk_in;
  task summarize;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_in) begin
    tick++;
    if (tick == 20000) begin
      num_errors++;
      summarize();
    end
  end
  function automatic logic [7:0] exp_cyc(tmx_place_t p, int n);
    if (p.src == TMX_MEM_EXT && p.dst == TMX_MEM_EXT) return 8'(4 * n + n * (p.wait_src + p.wait_dst));
    if (p.dst == TMX_MEM_EXT) return n == 1 ? 8'(4 + p.wait_dst) : 8'(2 * n + 2 + n * p.wait_dst);
    if (p.src_dst_same && n > 1) return 8'(2 * n);
    if (p.dst_code_same) return n == 1 ? 8'h04 : 8'(n + 3);
    return 8'(n + 2);
  endfunction
  task issue(input logic [15:0] i, input logic [15:0] r);
    int k;
    @(negedge clk_in);
    ins = i;
    repeat_next_instruction = r;
    pc = 16'($urandom);
    gim = 1'($urandom);
    cy = 1'($urandom);
    vld = 1'b1;
    @(negedge clk_in);
    vld = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge clk_in);
      k++;
    end
    if (k == 200) num_errors++;
    @(negedge clk_in);
    `CHK("carry", cy, cy_o)
    `CHK("mask", gim, gim_o)
  endtask
  task tw(input logic [15:0] i, input logic [15:0] r);
    b = tmx_mem_model_i.pma.size();
    issue(i, r);
    `CHK("words", 32'(r) + 1, tmx_mem_model_i.pma.size() - b)
    for (int k = 0; k <= int'(r); k++) begin
      `CHK("pm addr", acc_e[15:0] + 16'(k), tmx_mem_model_i.pma[b + k])
      `CHK("pm data", tmx_mem_model_i.rda[b + k] ^ 16'h5A3C, tmx_mem_model_i.pmd[b + k])
      if (!i[7]) `CHK("dm addr", {2'b00, dp, i[6:0]}, tmx_mem_model_i.rda[b + k])
    end
    `CHK("cycles", exp_cyc(pl, int'(r) + 1), cyc)
    `CHK("pc restore", pc + 16'h0001, pc_o)
  endtask
  initial begin
    void'($urandom(6));
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    for (int j = 0; j < 4; j++) begin
      lk = 16'($urandom);
      issue(OP_XOR_LK16, 16'h0000);
      acc_e[31:16] ^= lk;
      `CHK("acc hi xor", acc_e, acc)
      s = j == 0 ? 0 : j == 1 ? 15 : int'($urandom % 16);
      lk = 16'($urandom);
      issue({OP_XOR_LK_HI, 1'b0, OP_XOR_LK_LO, 4'(s)}, 16'h0000);
      acc_e ^= {16'h0000, lk} << s;
      `CHK("acc imm xor", acc_e, acc)
      xw = 16'($urandom);
      dp = 7'($urandom);
      fix = 1'b1;
      issue({OP_XOR, 1'b0, 7'($urandom)}, 16'h0000);
      fix = 1'b0;
      acc_e[15:0] ^= xw;
      `CHK("acc dir xor", acc_e, acc)
    end
    issue(OP_TRAP, 16'h0000);
    `CHK("trap pc", TRAP_VECTOR, pc_o)
    `CHK("trap push", pc + 16'h0001, push)
    for (int j = 0; j < 7; j++) begin
      pl = '0;
      pl.wait_src = 4'($urandom % 4);
      pl.wait_dst = 4'($urandom % 4);
      case (j)
        1: pl.dst = TMX_MEM_EXT;
        2: {pl.src, pl.dst} = {TMX_MEM_EXT, TMX_MEM_EXT};
        3: {pl.src, pl.dst, pl.src_dst_same} = {TMX_MEM_SINGLE_ACCESS_RAM, TMX_MEM_SINGLE_ACCESS_RAM, 1'b1};
        4: {pl.dst, pl.dst_code_same} = {TMX_MEM_SINGLE_ACCESS_RAM, 1'b1};
        5: pl.src = TMX_MEM_ROM;
        6: pl.dst = TMX_MEM_EXT;
        default: pl.src = TMX_MEM_DUAL_ACCESS_RAM;
      endcase
      tw({OP_DATA_TO_PROGRAM_TABLE_WRITE, 1'b0, 7'($urandom)}, j < 2 ? 16'h0000 : 16'($urandom % 4) + 16'h0001);
    end
    pl = '0;
    tw({OP_DATA_TO_PROGRAM_TABLE_WRITE, 1'b1, TMX_ARU_INC, 1'b0, 3'h0}, 16'h0002);
    for (int k = 0; k < 3; k++) `CHK("ind addr", 16'(k), tmx_mem_model_i.rda[b + k])
    `CHK("ar0 after inc", 16'h0003, ar)
    tw({OP_DATA_TO_PROGRAM_TABLE_WRITE, 1'b1, TMX_ARU_DEC, 1'b1, 3'h6}, 16'h0000);
    `CHK("ind addr dec", 16'h0003, tmx_mem_model_i.rda[b])
    `CHK("next pointer", 3'h6, aux_register_pointer)
    `CHK("ar6", 16'h0000, ar)
    tw({OP_DATA_TO_PROGRAM_TABLE_WRITE, 1'b1, TMX_ARU_ADD0, 1'b0, 3'h0}, 16'h0001);
    `CHK("ind addr add0", 16'h0002, tmx_mem_model_i.rda[b + 1])
    tw({OP_DATA_TO_PROGRAM_TABLE_WRITE, 1'b1, TMX_ARU_BR_ADD, 1'b0, 3'h0}, 16'h0000);
    `CHK("ind addr br", 16'h0004, tmx_mem_model_i.rda[b])
    `CHK("ar6 bit reversed", 16'h0006, ar)
    summarize();
  end
endmodule
`default_nettype wire
